/* core/srcs_pkg.sv */
// Functional notes
// - Code 130 arms the board, and on a clock master the whole synchronization group, for a later start.
// - Code 10 starts a run with the settings currently held.
// - Code 11 starts a run that signals its end by interrupt.
// - Board reports ready at run end; host waits for all ready.
// - Settings and memory survive runs; repeats need only re-arm onward.
// - Code 101 makes the board trigger master, driving the trigger bus.
// - Code 111 makes the board trigger slave, starting on bus triggers.
// - Code 100 makes the board sole clock master, driving the clock.
// - Code 110 makes the board clock slave using the shared clock.
package srcs_pkg;

  localparam logic [11:0] SRCS_OFF_COMMAND = 12'h000;
  localparam logic [11:0] SRCS_OFF_STATUS = 12'h004;
  localparam logic [11:0] SRCS_OFF_RUN_LEN = 12'h008;
  localparam logic [11:0] SRCS_OFF_ELAPSED = 12'h00C;
  localparam logic [11:0] SRCS_OFF_RUN_COUNT = 12'h010;

  localparam logic [31:0] SRCS_CMD_RUN_BEGIN = 32'h0000_000A;
  localparam logic [31:0] SRCS_CMD_RUN_BEGIN_IRQ = 32'h0000_000B;
  localparam logic [31:0] SRCS_CMD_CLK_MASTER = 32'h0000_0064;
  localparam logic [31:0] SRCS_CMD_TRIG_MASTER = 32'h0000_0065;
  localparam logic [31:0] SRCS_CMD_CLK_SLAVE = 32'h0000_006E;
  localparam logic [31:0] SRCS_CMD_TRIG_SLAVE = 32'h0000_006F;
  localparam logic [31:0] SRCS_CMD_ARM_GROUP = 32'h0000_0082;

  localparam int SRCS_ST_READY = 0;
  localparam int SRCS_ST_ARMED = 1;
  localparam int SRCS_ST_BUSY = 2;
  localparam int SRCS_ST_TRIG_MASTER = 3;
  localparam int SRCS_ST_TRIG_SLAVE = 4;
  localparam int SRCS_ST_CLK_MASTER = 5;
  localparam int SRCS_ST_CLK_SLAVE = 6;
  localparam int SRCS_ST_IRQ_MODE = 7;
  localparam int SRCS_ST_IRQ_PEND = 8;

  localparam logic [31:0] SRCS_RST_COMMAND = 32'h0000_0000;
  localparam logic [31:0] SRCS_RST_RUN_LEN = 32'h0000_0400;
  localparam logic [7:0] SRCS_SYNC_CLK_HALF = 8'h04;

  typedef enum logic [1:0] {
    SRCS_IDLE = 2'b00,
    SRCS_WAIT_TRIG = 2'b01,
    SRCS_RUN = 2'b10
  } srcs_state_t;

endpackage

/* core/srcs_top.sv */
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module srcs_top
  import srcs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trig_in,
  input wire logic trig_bus_in,
  output logic trig_bus_out,
  output logic trig_bus_oe,
  input wire logic sync_arm_in,
  output logic sync_arm_out,
  output logic sync_arm_oe,
  output logic sync_clk_out,
  output logic sync_clk_oe,
  output logic clk_src_shared,
  output logic run_active,
  output logic run_irq
);

  srcs_state_t state_q;
  logic [31:0] command_q;
  logic [31:0] run_len_q;
  logic [31:0] elapsed_q;
  logic [31:0] run_count_q;
  logic ready_q;
  logic armed_q;
  logic irq_mode_q;
  logic irq_pend_q;
  logic trig_master_q;
  logic trig_slave_q;
  logic clk_master_q;
  logic clk_slave_q;
  logic [2:0] ext_sync_q;
  logic [2:0] bus_sync_q;
  logic [2:0] arm_sync_q;
  logic [7:0] div_cnt_q;
  logic [31:0] rdata_d;
  logic addr_ok;
  logic wr_fire;
  logic wr_cmd;
  logic start_cmd;
  logic start_ok;
  logic ext_edge;
  logic bus_edge;
  logic arm_edge;
  logic run_done;
  logic trig_hit;
  logic irq_clr;

  function automatic logic [31:0] srcs_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Zero wait state would need a combinational pready; one cycle is the trade
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      end
    end
  end

  always_comb begin
    addr_ok = (paddr == SRCS_OFF_COMMAND) || (paddr == SRCS_OFF_STATUS) ||
              (paddr == SRCS_OFF_RUN_LEN) || (paddr == SRCS_OFF_ELAPSED) ||
              (paddr == SRCS_OFF_RUN_COUNT);
    wr_fire = psel && penable && pready && pwrite && addr_ok;
    wr_cmd = wr_fire && (paddr == SRCS_OFF_COMMAND);
    irq_clr = wr_fire && (paddr == SRCS_OFF_STATUS) && pstrb[1] &&
              pwdata[SRCS_ST_IRQ_PEND];
    start_cmd = wr_cmd && ((pwdata == SRCS_CMD_RUN_BEGIN) ||
                           (pwdata == SRCS_CMD_RUN_BEGIN_IRQ));
    start_ok = start_cmd && armed_q && (state_q == SRCS_IDLE);
    ext_edge = ext_sync_q[1] && !ext_sync_q[2];
    bus_edge = bus_sync_q[1] && !bus_sync_q[2];
    arm_edge = arm_sync_q[1] && !arm_sync_q[2];
    run_done = (state_q == SRCS_RUN) && (elapsed_q + 32'h0000_0001 >= run_len_q);
    trig_hit = trig_slave_q ? bus_edge : ext_edge;
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      SRCS_OFF_COMMAND: rdata_d = command_q;
      SRCS_OFF_STATUS: begin
        rdata_d[SRCS_ST_READY] = ready_q;
        rdata_d[SRCS_ST_ARMED] = armed_q;
        rdata_d[SRCS_ST_BUSY] = (state_q != SRCS_IDLE);
        rdata_d[SRCS_ST_TRIG_MASTER] = trig_master_q;
        rdata_d[SRCS_ST_TRIG_SLAVE] = trig_slave_q;
        rdata_d[SRCS_ST_CLK_MASTER] = clk_master_q;
        rdata_d[SRCS_ST_CLK_SLAVE] = clk_slave_q;
        rdata_d[SRCS_ST_IRQ_MODE] = irq_mode_q;
        rdata_d[SRCS_ST_IRQ_PEND] = irq_pend_q;
      end
      SRCS_OFF_RUN_LEN: rdata_d = run_len_q;
      SRCS_OFF_ELAPSED: rdata_d = elapsed_q;
      SRCS_OFF_RUN_COUNT: rdata_d = run_count_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Pins from other boards are asynchronous; stage 0 feeds only stage 1
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_sync_q <= 3'b000;
      bus_sync_q <= 3'b000;
      arm_sync_q <= 3'b000;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_trig_in};
      bus_sync_q <= {bus_sync_q[1:0], trig_bus_in};
      arm_sync_q <= {arm_sync_q[1:0], sync_arm_in};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      command_q <= SRCS_RST_COMMAND;
      run_len_q <= SRCS_RST_RUN_LEN;
    end else if (wr_fire) begin
      // Settings are never touched by a run, so a repeat needs only re-arming
      if (paddr == SRCS_OFF_COMMAND) begin
        command_q <= pwdata;
      end
      if (paddr == SRCS_OFF_RUN_LEN) begin
        run_len_q <= srcs_merge(run_len_q, pwdata, pstrb);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      trig_master_q <= 1'b0;
      trig_slave_q <= 1'b0;
    end else if (wr_cmd && (pwdata == SRCS_CMD_TRIG_MASTER)) begin
      trig_master_q <= 1'b1;
      trig_slave_q <= 1'b0;
    end else if (wr_cmd && (pwdata == SRCS_CMD_TRIG_SLAVE)) begin
      trig_master_q <= 1'b0;
      trig_slave_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clk_master_q <= 1'b0;
      clk_slave_q <= 1'b0;
    end else if (wr_cmd && (pwdata == SRCS_CMD_CLK_MASTER)) begin
      clk_master_q <= 1'b1;
      clk_slave_q <= 1'b0;
    end else if (wr_cmd && (pwdata == SRCS_CMD_CLK_SLAVE)) begin
      clk_master_q <= 1'b0;
      clk_slave_q <= 1'b1;
    end
  end

  // Arming is consumed by the start it enables
  always_ff @(posedge clk) begin
    if (srst) begin
      armed_q <= 1'b0;
    end else if (start_ok) begin
      armed_q <= 1'b0;
    end else if (wr_cmd && (pwdata == SRCS_CMD_ARM_GROUP)) begin
      armed_q <= 1'b1;
    end else if (arm_edge && !clk_master_q) begin
      armed_q <= 1'b1;
    end
  end

  // Master holds the arm line while armed so slaves see a wide level
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_arm_out <= 1'b0;
      sync_arm_oe <= 1'b0;
    end else begin
      sync_arm_out <= clk_master_q && armed_q;
      sync_arm_oe <= clk_master_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= SRCS_IDLE;
      elapsed_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        SRCS_IDLE: begin
          if (start_ok) begin
            state_q <= SRCS_WAIT_TRIG;
            elapsed_q <= 32'h0000_0000;
          end
        end
        SRCS_WAIT_TRIG: begin
          if (trig_hit) begin
            state_q <= SRCS_RUN;
          end
        end
        SRCS_RUN: begin
          elapsed_q <= elapsed_q + 32'h0000_0001;
          if (run_done) begin
            state_q <= SRCS_IDLE;
          end
        end
        default: state_q <= SRCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ready_q <= 1'b1;
      run_count_q <= 32'h0000_0000;
    end else if (start_ok) begin
      ready_q <= 1'b0;
    end else if (run_done) begin
      ready_q <= 1'b1;
      run_count_q <= run_count_q + 32'h0000_0001;
    end
  end

  // End of run beats a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_mode_q <= 1'b0;
      irq_pend_q <= 1'b0;
    end else begin
      if (start_ok) begin
        irq_mode_q <= (pwdata == SRCS_CMD_RUN_BEGIN_IRQ);
      end
      if (run_done && irq_mode_q) begin
        irq_pend_q <= 1'b1;
      end else if (irq_clr) begin
        irq_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      run_irq <= 1'b0;
      run_active <= 1'b0;
    end else begin
      run_irq <= irq_pend_q;
      run_active <= (state_q == SRCS_RUN);
    end
  end

  // Only a started master forwards its own trigger to the group
  always_ff @(posedge clk) begin
    if (srst) begin
      trig_bus_out <= 1'b0;
      trig_bus_oe <= 1'b0;
    end else begin
      trig_bus_out <= trig_master_q && (state_q == SRCS_WAIT_TRIG) && ext_edge;
      trig_bus_oe <= trig_master_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt_q <= 8'h00;
      sync_clk_out <= 1'b0;
      sync_clk_oe <= 1'b0;
      clk_src_shared <= 1'b0;
    end else begin
      sync_clk_oe <= clk_master_q;
      clk_src_shared <= clk_slave_q;
      if (!clk_master_q) begin
        div_cnt_q <= 8'h00;
        sync_clk_out <= 1'b0;
      end else if (div_cnt_q == SRCS_SYNC_CLK_HALF - 8'h01) begin
        div_cnt_q <= 8'h00;
        sync_clk_out <= !sync_clk_out;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* test/srcs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module srcs_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trig_bus_out,
  input wire logic trig_bus_oe,
  input wire logic sync_arm_out,
  input wire logic sync_arm_oe,
  input wire logic sync_clk_out,
  input wire logic sync_clk_oe,
  input wire logic clk_src_shared,
  input wire logic run_active,
  input wire logic run_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_done; pready ##1 !pready; endsequence
  property p_answer; $rose(penable) && psel |-> s_wait ##1 s_done; endproperty
  a_answer: assert property (p_answer) else $error("apb answer late or long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_clk_off; !sync_clk_oe |-> !sync_clk_out; endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock driven while not master");
  // Stable only because the bench never leaves clock master once there
  property p_clk_div; $rose(sync_clk_out) |-> sync_clk_out[*4] ##1 !sync_clk_out[*4] ##1 sync_clk_out; endproperty
  a_clk_div: assert property (p_clk_div) else $error("shared clock period wrong");
  property p_oe_pair; sync_clk_oe == sync_arm_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("master enables disagree");
  property p_clk_slave; clk_src_shared |-> !sync_clk_oe && !sync_arm_oe; endproperty
  a_clk_slave: assert property (p_clk_slave) else $error("slave drives clock");
  property p_arm_out; sync_arm_out |-> sync_arm_oe; endproperty
  a_arm_out: assert property (p_arm_out) else $error("arm line driven by non-master");
  property p_trig_out; trig_bus_out |-> trig_bus_oe ##1 !trig_bus_out; endproperty
  a_trig_out: assert property (p_trig_out) else $error("bad trigger forward");
  property p_irq; $rose(run_irq) |-> !run_active; endproperty
  a_irq: assert property (p_irq) else $error("irq before run end");
endmodule
bind srcs_top srcs_assertions chk_u (.clk, .srst, .psel, .penable, .pready, .pslverr,
  .trig_bus_out, .trig_bus_oe, .sync_arm_out, .sync_arm_oe, .sync_clk_out, .sync_clk_oe,
  .clk_src_shared, .run_active, .run_irq);
`default_nettype wire

/* test/srcs_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module srcs_peer (
  input wire logic clk,
  output logic ext_trig,
  output logic bus_trig,
  output logic arm
);
  // Idle low, as pulled down; held 4 cycles to pass the input synchronizers
  initial begin
    ext_trig = 1'b0;
    bus_trig = 1'b0;
    arm = 1'b0;
  end
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: ext_trig <= 1'b1;
      1: bus_trig <= 1'b1;
      default: arm <= 1'b1;
    endcase
    repeat (4) @(posedge clk);
    ext_trig <= 1'b0;
    bus_trig <= 1'b0;
    arm <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srcs_pkg::*;
  localparam logic [11:0] ST = SRCS_OFF_STATUS;
  localparam logic [11:0] CM = SRCS_OFF_COMMAND;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata, seed = 32'h0001_1A8F;
  logic pready, pslverr, ext_t, bus_t, arm_t, trig_bus_out, trig_bus_oe, sync_arm_out;
  logic sync_arm_oe, sync_clk_out, sync_clk_oe, clk_src_shared, run_active, run_irq;
  int failures = 0, compares = 0;
  int fwd = 0;
  always #12.5 clk = ~clk;
  // Count forwarded trigger pulses; each one stands a single cycle
  always @(posedge clk) begin
    if (trig_bus_out === 1'b1) fwd <= fwd + 1;
  end
  srcs_top dut_u (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .ext_trig_in(ext_t), .trig_bus_in(bus_t), .trig_bus_out,
    .trig_bus_oe, .sync_arm_in(arm_t), .sync_arm_out, .sync_arm_oe, .sync_clk_out,
    .sync_clk_oe, .clk_src_shared, .run_active, .run_irq);
  srcs_peer peer_u (.clk, .ext_trig(ext_t), .bus_trig(bus_t), .arm(arm_t));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task test_done;
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    if (n >= 64) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
  endtask
  // Host side polls; bounded so a stuck run ends as a mismatch
  task wait_ready;
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, ST, 32'h0000_0000);
      if (rd[SRCS_ST_READY] === 1'b1) break;
    end
    chk({31'h0000_0000, rd[SRCS_ST_READY]}, 32'h0000_0001);
  endtask
  initial begin
    logic [31:0] len;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdm(ST, 32'h0000_01FF, 32'h0000_0001);
    rdm(SRCS_OFF_RUN_LEN, '1, 32'h0000_0400);
    rdm(CM, '1, 32'h0000_0000);
    rdm(12'h020, '1, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, CM, SRCS_CMD_RUN_BEGIN);
    rdm(ST, 32'h0000_01FF, 32'h0000_0001);
    apb(1'b1, SRCS_OFF_RUN_LEN, 32'h0000_0010);
    pstrb <= 4'h1;
    apb(1'b1, SRCS_OFF_RUN_LEN, 32'hFFFF_FF20);
    pstrb <= 4'hF;
    rdm(SRCS_OFF_RUN_LEN, '1, 32'h0000_0020);
    apb(1'b1, CM, SRCS_CMD_CLK_SLAVE);
    apb(1'b1, CM, SRCS_CMD_TRIG_SLAVE);
    rdm(ST, 32'h0000_0078, 32'h0000_0050);
    chk({31'h0000_0000, clk_src_shared}, 32'h0000_0001);
    peer_u.pulse(2);
    rdm(ST, 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, CM, SRCS_CMD_RUN_BEGIN);
    rdm(ST, 32'h0000_0007, 32'h0000_0004);
    peer_u.pulse(0);
    rdm(ST, 32'h0000_0005, 32'h0000_0004);
    chk({31'h0000_0000, run_active}, 32'h0000_0000);
    peer_u.pulse(1);
    wait_ready;
    rdm(SRCS_OFF_RUN_COUNT, '1, 32'h0000_0001);
    apb(1'b1, CM, SRCS_CMD_CLK_MASTER);
    apb(1'b1, CM, SRCS_CMD_TRIG_MASTER);
    rdm(ST, 32'h0000_0078, 32'h0000_0028);
    chk({31'h0000_0000, sync_clk_oe}, 32'h0000_0001);
    chk({31'h0000_0000, trig_bus_oe}, 32'h0000_0001);
    peer_u.pulse(2);
    rdm(ST, 32'h0000_0002, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      len = (i == 0) ? 32'h0000_0001 : {27'h000_0000, seed[4:0]} + 32'h0000_0001;
      apb(1'b1, SRCS_OFF_RUN_LEN, len);
      apb(1'b1, CM, SRCS_CMD_ARM_GROUP);
      rdm(ST, 32'h0000_0002, 32'h0000_0002);
      chk({31'h0000_0000, sync_arm_out}, 32'h0000_0001);
      apb(1'b1, CM, i[0] ? SRCS_CMD_RUN_BEGIN_IRQ : SRCS_CMD_RUN_BEGIN);
      peer_u.pulse(0);
      wait_ready;
      rdm(SRCS_OFF_ELAPSED, '1, len);
      rdm(SRCS_OFF_RUN_COUNT, '1, 32'(i + 2));
      rdm(SRCS_OFF_RUN_LEN, '1, len);
      rdm(ST, 32'h0000_0100, i[0] ? 32'h0000_0100 : 32'h0000_0000);
      chk({31'h0000_0000, run_irq}, {31'h0000_0000, i[0]});
      apb(1'b1, ST, 32'h0000_0100);
    end
    chk(32'(fwd), 32'h0000_0004);
    apb(1'b1, CM, SRCS_CMD_RUN_BEGIN);
    rdm(ST, 32'h0000_0107, 32'h0000_0001);
    rdm(CM, '1, SRCS_CMD_RUN_BEGIN);
    test_done;
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
